/* rtl/fc_counter.v */
// down counter used to time collision avoidance phases
// assumes a per-carrier-period enable from the parent
`timescale 1ns/10ps
`default_nettype none
module fc_counter (
  input wire core_clk,
  input wire rst_n,
  input wire load,
  input wire [31:0] load_value,
  input wire tick,
  output wire done
);
  reg [31:0] count;
  // ==========================================================
  // load then count down on each tick until zero
  always @(posedge core_clk) begin
    if (!rst_n) begin
      count <= 32'h00000000;
    end else if (load) begin
      count <= load_value;
    end else if (tick && count != 32'h00000000) begin
      count <= count - 32'h00000001;
    end
  end
  assign done = (count == 32'h00000000) && !load; // expiry level
endmodule // fc_counter
`default_nettype wire

/* rtl/nfc_cmd_defines.vh */
// constants for the direct command executor: codes, bits, timing counts
// assumes inclusion by bare name from the design files
`ifndef NFC_CMD_DEFINES_VH
`define NFC_CMD_DEFINES_VH
// ==========================================================
// command codes
`define CMD_SET_DEFAULT 8'hc1
`define CMD_CLEAR 8'hc2
`define CMD_TX_CRC 8'hc4
`define CMD_TX_NOCRC 8'hc5
`define CMD_TX_REQA 8'hc6
`define CMD_TX_WUPA 8'hc7
`define CMD_FIELD_INIT 8'hc8
`define CMD_FIELD_RESP 8'hc9
`define CMD_FIELD_RESP0 8'hca
`define CMD_GO_NORMAL 8'hcb
`define CMD_ADJ_REG 8'hd6
`define CMD_MASK_TIMER 8'he2
// ==========================================================
// register offsets (chosen)
`define REG_OP_CTRL 8'h02
`define REG_AUX_DEF 8'h09
`define REG_MODE_DEF 8'h03
`define REG_BITRATE 8'h04
`define REG_IRQ 8'h1a
`define REG_STATUS 8'h1b
`define REG_COMMAND 8'h1c
// field positions
`define OP_EN_BIT 7
`define OP_TX_EN_BIT 3
`define AUX_TXMOD_BIT 5
`define AUX_N_HI_BIT 1
`define AUX_N_LO_BIT 0
`define MODE_AR_BIT 0
`define MODE_BRDET_BIT 1
`define MODE_NRT_KEEP_BIT 2
`define MODE_REG_EXT_BIT 3
`define MODE_ACT_TGT_BIT 4
`define IRQ_CAT_BIT 0
`define IRQ_CAC_BIT 1
// reset values
`define RST_OP_CTRL 8'h00
`define RST_AUX_DEF 8'h00
`define RST_MODE_DEF 8'h00
`define RST_BITRATE 8'h00
// ==========================================================
// timing: carrier periods and guard time
`define T_IDT_FC 4096
`define T_RWF_FC 512
`define T_ADT_FC 768
`define T_ARFG_FC 1024
`define T_IRFG_MS 5
`define CLK_HZ 50000000
`endif

/* rtl/nfc_direct_command_executor.v */
// direct command executor for set default, clear, transmit, field on
// and go-to-normal; assumes strobes synchronous to core_clk
`timescale 1ns/10ps
`default_nettype none
`include "nfc_cmd_defines.vh"
module nfc_direct_command_executor #(
  parameter GUARD_CYCLES = (`T_IRFG_MS * (`CLK_HZ / 1000)) + 1,
  parameter FC_DIV = 4
) (
  input wire core_clk,
  input wire rst_n,
  input wire [7:0] addr,
  input wire [7:0] wdata,
  input wire wr_stb,
  input wire rd_stb,
  output reg [7:0] rdata,
  input wire osc_freq_ok,
  input wire osc_ampl_ok,
  input wire ext_field,
  input wire [7:0] detected_bitrate,
  input wire fifo_busy,
  output reg fifo_flush,
  output reg tx_abort,
  output reg timers_stop,
  output reg nrt_stop,
  output reg tx_start,
  output reg [1:0] tx_kind,
  output reg adj_reg_start,
  output reg mask_timer_start,
  output reg cal_discard
);
  // ==========================================================
  // state
  localparam ST_IDLE = 2'd0;
  localparam ST_DELAY = 2'd1;
  localparam ST_SENSE = 2'd2;
  localparam ST_GUARD = 2'd3;
  reg [1:0] state;
  reg [1:0] next_state;
  reg [7:0] op_ctrl;
  reg [7:0] aux_def;
  reg [7:0] mode_def;
  reg [7:0] bitrate;
  reg [7:0] irq;
  reg [7:0] fc_pre;
  reg resp_kind;
  reg ld;
  reg [31:0] ld_val;
  wire fc_tick;
  wire ph_done;
  wire cmd_wr;
  wire [7:0] cmd;
  wire en_ok;
  wire [1:0] n_sel;
  wire [31:0] n_wait;
  wire av_busy;
  assign cmd_wr = wr_stb && (addr == `REG_COMMAND);
  assign cmd = wdata;
  assign en_ok = op_ctrl[`OP_EN_BIT];
  assign n_sel = {aux_def[`AUX_N_HI_BIT], aux_def[`AUX_N_LO_BIT]};
  assign n_wait = {30'd0, n_sel} * `T_RWF_FC;
  assign av_busy = (state != ST_IDLE);
  // ==========================================================
  // carrier period enable from divider
  always @(posedge core_clk) begin
    if (!rst_n) begin
      fc_pre <= 8'h00;
    end else if (fc_pre == FC_DIV[7:0] - 8'h01) begin
      fc_pre <= 8'h00;
    end else begin
      fc_pre <= fc_pre + 8'h01;
    end
  end
  assign fc_tick = (fc_pre == FC_DIV[7:0] - 8'h01);
  // ==========================================================
  // acceptance of each command, refused ones have no effect
  wire acc_setdef = cmd_wr && (cmd == `CMD_SET_DEFAULT);
  wire acc_clear = cmd_wr && (cmd == `CMD_CLEAR) &&
    en_ok && osc_freq_ok;
  wire is_tx = (cmd == `CMD_TX_CRC) || (cmd == `CMD_TX_NOCRC) ||
    (cmd == `CMD_TX_REQA) || (cmd == `CMD_TX_WUPA);
  wire acc_tx = cmd_wr && is_tx && en_ok &&
    op_ctrl[`OP_TX_EN_BIT];
  wire is_field = (cmd == `CMD_FIELD_INIT) ||
    (cmd == `CMD_FIELD_RESP) || (cmd == `CMD_FIELD_RESP0);
  wire acc_field = cmd_wr && is_field && en_ok && osc_freq_ok &&
    osc_ampl_ok;
  wire acc_norm = cmd_wr && (cmd == `CMD_GO_NORMAL) &&
    mode_def[`MODE_BRDET_BIT];
  wire acc_adj = cmd_wr && (cmd == `CMD_ADJ_REG) && en_ok &&
    !mode_def[`MODE_REG_EXT_BIT];
  wire acc_mask = cmd_wr && (cmd == `CMD_MASK_TIMER) &&
    mode_def[`MODE_ACT_TGT_BIT];
  // clear stops avoidance unless auto response avoid is set
  wire av_kill = acc_setdef ||
    (acc_clear && !mode_def[`MODE_AR_BIT]);
  // ==========================================================
  // avoidance sequencer next state
  always @* begin
    next_state = state;
    ld = 1'b0;
    ld_val = 32'h00000000;
    case (state)
      ST_IDLE: begin
        if (acc_field) begin
          next_state = ST_DELAY;
          ld = 1'b1;
          if (cmd == `CMD_FIELD_INIT) begin
            ld_val = `T_IDT_FC + n_wait;
          end else if (cmd == `CMD_FIELD_RESP) begin
            ld_val = `T_ADT_FC + n_wait;
          end else begin
            ld_val = `T_ADT_FC;
          end
        end
      end
      ST_DELAY: begin
        if (ph_done) begin
          next_state = ST_SENSE;
        end
      end
      ST_SENSE: begin
        if (ext_field) begin
          next_state = ST_IDLE;
        end else begin
          next_state = ST_GUARD;
          ld = 1'b1;
          ld_val = resp_kind ? `T_ARFG_FC :
            (GUARD_CYCLES + FC_DIV - 1) / FC_DIV;
        end
      end
      ST_GUARD: begin
        if (ph_done) begin
          next_state = ST_IDLE;
        end
      end
      default: begin
        next_state = ST_IDLE;
      end
    endcase
    if (av_kill) begin
      next_state = ST_IDLE;
      ld = 1'b0;
    end
  end
  fc_counter u_phase (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .load(ld),
    .load_value(ld_val),
    .tick(fc_tick),
    .done(ph_done)
  );
  // ==========================================================
  // sequencer state and register file
  always @(posedge core_clk) begin
    if (!rst_n) begin
      state <= ST_IDLE;
      resp_kind <= 1'b0;
      op_ctrl <= `RST_OP_CTRL;
      aux_def <= `RST_AUX_DEF;
      mode_def <= `RST_MODE_DEF;
      bitrate <= `RST_BITRATE;
      irq <= 8'h00;
    end else begin
      state <= next_state;
      if (acc_field && state == ST_IDLE) begin
        resp_kind <= (cmd != `CMD_FIELD_INIT);
      end
      // software register writes
      if (wr_stb && addr == `REG_OP_CTRL) begin
        op_ctrl <= wdata;
      end
      if (wr_stb && addr == `REG_AUX_DEF) begin
        aux_def <= wdata;
      end
      if (wr_stb && addr == `REG_MODE_DEF) begin
        mode_def <= wdata;
      end
      if (wr_stb && addr == `REG_BITRATE) begin
        bitrate <= wdata;
      end
      // go normal: leave detection, copy rate, pick modulation
      if (acc_norm) begin
        mode_def[`MODE_BRDET_BIT] <= 1'b0;
        bitrate <= detected_bitrate;
        aux_def[`AUX_TXMOD_BIT] <= (detected_bitrate[1:0] != 2'b00);
      end
      // default restore, operation control kept
      if (acc_setdef) begin
        aux_def <= `RST_AUX_DEF;
        mode_def <= `RST_MODE_DEF;
        bitrate <= `RST_BITRATE;
      end
      // interrupt register: clear first, hardware set wins except against a set default or a clear that stops avoidance
      if (acc_clear || acc_setdef) begin
        irq <= 8'h00;
      end else if (rd_stb && addr == `REG_IRQ) begin
        irq <= 8'h00;
      end
      if (state == ST_SENSE && ext_field && !av_kill) begin
        irq[`IRQ_CAC_BIT] <= 1'b1;
      end
      if (state == ST_SENSE && !ext_field && !av_kill) begin
        op_ctrl[`OP_TX_EN_BIT] <= 1'b1;
      end
      if (state == ST_GUARD && ph_done && !av_kill) begin
        irq[`IRQ_CAT_BIT] <= 1'b1;
      end
    end
  end
  // ==========================================================
  // one-cycle command pulses, transmit kind held until the next transmit
  always @(posedge core_clk) begin
    if (!rst_n) begin
      fifo_flush <= 1'b0;
      tx_abort <= 1'b0;
      timers_stop <= 1'b0;
      nrt_stop <= 1'b0;
      tx_start <= 1'b0;
      tx_kind <= 2'b00;
      adj_reg_start <= 1'b0;
      mask_timer_start <= 1'b0;
      cal_discard <= 1'b0;
    end else begin
      fifo_flush <= acc_clear || (acc_setdef && en_ok);
      tx_abort <= acc_clear || acc_setdef;
      timers_stop <= acc_clear || acc_setdef;
      nrt_stop <= acc_setdef ||
        (acc_clear && !mode_def[`MODE_NRT_KEEP_BIT]);
      tx_start <= acc_tx;
      if (acc_tx) begin
        tx_kind <= cmd[1:0] ^ 2'b00;
      end
      adj_reg_start <= acc_adj;
      mask_timer_start <= acc_mask;
      cal_discard <= acc_setdef;
    end
  end
  // ==========================================================
  // read data, one cycle after read strobe
  always @(posedge core_clk) begin
    if (!rst_n) begin
      rdata <= 8'h00;
    end else if (rd_stb) begin
      case (addr)
        `REG_OP_CTRL: rdata <= op_ctrl;
        `REG_AUX_DEF: rdata <= aux_def;
        `REG_MODE_DEF: rdata <= mode_def;
        `REG_BITRATE: rdata <= bitrate;
        `REG_IRQ: rdata <= irq;
        `REG_STATUS: rdata <= {5'h00, fifo_busy, state};
        default: rdata <= 8'h00;
      endcase
    end else begin
      rdata <= 8'h00;
    end
  end
endmodule // nfc_direct_command_executor
`default_nettype wire

/* test/nfc_cmd_checker_assertions.sv */
// checker: port properties of the direct command executor
// assumes a bind from the bench onto the executor top
`timescale 1ns/10ps
`default_nettype none
module nfc_cmd_checker (
  input wire core_clk,
  input wire rst_n,
  input wire [7:0] addr,
  input wire [7:0] wdata,
  input wire wr_stb,
  input wire osc_freq_ok,
  input wire fifo_flush,
  input wire tx_abort,
  input wire timers_stop,
  input wire nrt_stop,
  input wire tx_start,
  input wire [1:0] tx_kind,
  input wire adj_reg_start,
  input wire mask_timer_start,
  input wire cal_discard
);
  // ====================
  // command write detection
  default clocking dc @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  wire cmd_w = wr_stb && addr == 8'h1c;
  sequence s_cmd(c);
    cmd_w && wdata == c;
  endsequence
  // ====================
  // properties
  AST_CLR_REFUSE: assert property (
    s_cmd(8'hc2) ##0 !osc_freq_ok |=> !fifo_flush)
    else $error("clear taken without stable oscillator");
  AST_CLR_GROUP: assert property (
    fifo_flush && !cal_discard |-> tx_abort && timers_stop
    && $past(cmd_w) && $past(wdata) == 8'hc2)
    else $error("flush without full clear group");
  AST_CLR_PULSE: assert property (
    s_cmd(8'hc2) ##1 fifo_flush |=> !fifo_flush)
    else $error("flush pulse longer than one cycle");
  AST_NRT: assert property (nrt_stop |-> timers_stop)
    else $error("no-response stop outside clear");
  AST_TX_CAUSE: assert property (
    tx_start |-> $past(cmd_w) && $past(wdata[7:2]) == 6'h31
    && tx_kind == $past(wdata[1:0]))
    else $error("transmit start without transmit command");
  AST_DEF_TAKEN: assert property (s_cmd(8'hc1) |=> cal_discard)
    else $error("set default not taken");
  AST_DEF_CAUSE: assert property (
    cal_discard |-> $past(cmd_w) && $past(wdata) == 8'hc1)
    else $error("discard without set default");
  AST_ADJ: assert property (
    adj_reg_start |-> $past(cmd_w) && $past(wdata) == 8'hd6)
    else $error("regulator adjust without command");
  AST_MASK: assert property (
    mask_timer_start |-> $past(cmd_w) && $past(wdata) == 8'he2)
    else $error("mask timer start without command");
endmodule // nfc_cmd_checker
`default_nettype wire

/* test/nfc_host_model.sv */
// host model: register bus master with write and read tasks
// assumes callers enter just after a rising core_clk edge
`timescale 1ns/10ps
`default_nettype none
module nfc_host_model (
  input wire core_clk,
  input wire [7:0] rdata,
  output logic [7:0] addr,
  output logic [7:0] wdata,
  output logic wr_stb,
  output logic rd_stb
);
  // ====================
  // bus cycles
  initial begin
    addr = 8'h00;
    wdata = 8'h00;
    wr_stb = 1'b0;
    rd_stb = 1'b0;
  end
  // one write, then an idle cycle so commands never chain
  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    addr <= a;
    wdata <= v;
    wr_stb <= 1'b1;
    @(posedge core_clk);
    wr_stb <= 1'b0;
    addr <= ~a;
    wdata <= ~v;
    @(posedge core_clk);
  endtask
  // one read; data taken in the cycle after the strobe
  task automatic rd(input logic [7:0] a, output logic [7:0] v);
    addr <= a;
    rd_stb <= 1'b1;
    @(posedge core_clk);
    rd_stb <= 1'b0;
    addr <= ~a;
    #1 v = rdata;
    @(posedge core_clk);
  endtask
endmodule // nfc_host_model
`default_nettype wire

/* test/tb.sv */
// bench: model-checked commands, field on timing, register reads
// assumes executor, host model and checker compiled first
`timescale 1ns/10ps
`default_nettype none
module tb;
  localparam int D = 2;
  localparam int G = 40;
  logic core_clk = 1'b0;
  logic rst_n = 1'b0;
  logic osc_freq_ok = 1'b1;
  logic osc_ampl_ok = 1'b1;
  logic ext_field = 1'b0;
  logic fifo_busy = 1'b0;
  logic [7:0] detected_bitrate = 8'h00;
  wire [7:0] addr, wdata, rdata;
  wire wr_stb, rd_stb, fifo_flush, tx_abort, timers_stop, nrt_stop;
  wire tx_start, adj_reg_start, mask_timer_start, cal_discard;
  wire [1:0] tx_kind;
  logic [7:0] seen = 8'h00;
  logic [7:0] op, mode, r, d;
  logic [7:0] ops [3] = '{8'h00, 8'h80, 8'h88};
  logic [7:0] mds [4] = '{8'h00, 8'h04, 8'h08, 8'h10};
  logic [7:0] cds [7] = '{8'hc2, 8'hc4, 8'hc5, 8'hc6, 8'hc7, 8'hd6, 8'he2};
  logic [31:0] seed = 32'h00009b12;
  int cyc = 0;
  int err_total = 0;
  int checks = 0;
  nfc_direct_command_executor #(.GUARD_CYCLES(G), .FC_DIV(D))
    i_nfc_direct_command_executor (.core_clk(core_clk), .rst_n(rst_n),
    .addr(addr), .wdata(wdata), .wr_stb(wr_stb), .rd_stb(rd_stb),
    .rdata(rdata), .osc_freq_ok(osc_freq_ok), .osc_ampl_ok(osc_ampl_ok),
    .ext_field(ext_field), .detected_bitrate(detected_bitrate),
    .fifo_busy(fifo_busy), .fifo_flush(fifo_flush), .tx_abort(tx_abort),
    .timers_stop(timers_stop), .nrt_stop(nrt_stop), .tx_start(tx_start),
    .tx_kind(tx_kind), .adj_reg_start(adj_reg_start),
    .mask_timer_start(mask_timer_start), .cal_discard(cal_discard));
  nfc_host_model host (.core_clk(core_clk), .rdata(rdata), .addr(addr),
    .wdata(wdata), .wr_stb(wr_stb), .rd_stb(rd_stb));
  // ====================
  // clock, cycle count and pulse collection per command
  always #10 core_clk = ~core_clk;
  always @(posedge core_clk) begin
    cyc <= cyc + 1;
    if (wr_stb) seen <= 8'h00;
    else seen <= seen | {fifo_flush, tx_abort, timers_stop, nrt_stop,
      tx_start, adj_reg_start, mask_timer_start, cal_discard};
  end
  function automatic logic [7:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed[7:0];
  endfunction
  // expected pulses from the model state
  function automatic logic [7:0] exp_p(input logic [7:0] c);
    case (c)
      8'hc1: return 8'h01;
      8'hc2: return (op[7] && osc_freq_ok) ? {3'b111, ~mode[2], 4'h0} : 0;
      8'hd6: return (op[7] && !mode[3]) ? 8'h04 : 8'h00;
      8'he2: return mode[4] ? 8'h02 : 8'h00;
      default: return (op[7] && op[3]) ? 8'h08 : 8'h00;
    endcase
  endfunction
  task automatic chk(input string n, input logic [15:0] e,
      input logic [15:0] g);
    checks++;
    if (g !== e) begin
      err_total++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic cmd(input logic [7:0] c, input logic [7:0] m);
    logic [7:0] e;
    host.wr(8'h1c, c);
    @(posedge core_clk);
    e = exp_p(c) & m;
    chk("pulses", {8'h00, e}, {8'h00, seen & m});
    if (e[3]) chk("tx_kind", {14'h0, c[1:0]}, {14'h0, tx_kind});
  endtask
  // field on: poll the irq register, check outcome and elapsed cycles
  task automatic fon(input logic [7:0] c, input logic [7:0] n,
      input logic x, input int t);
    int t0;
    int k;
    logic [7:0] v;
    host.wr(8'h09, n);
    ext_field <= x;
    t0 = cyc;
    host.wr(8'h1c, c);
    v = 8'h00;
    for (k = 0; k < 9000 && v == 8'h00; k++) host.rd(8'h1a, v);
    chk("irq", {14'h0, x, !x}, {8'h00, v});
    if (!x) chk("delay", 16'h1, {15'h0, (cyc - t0 + 4 >= t)
      && (cyc - t0 <= t + 32)});
    host.rd(8'h02, v);
    chk("tx on", {15'h0, !x}, {15'h0, v[3]});
    host.wr(8'h02, 8'h80);
  endtask
  task automatic final_report();
    if (err_total == 0 && checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  // ====================
  // main sequence
  initial begin
    op = 8'h00;
    mode = 8'h00;
    repeat (16) @(posedge core_clk);
    rst_n <= 1'b1;
    @(posedge core_clk);
    host.wr(8'h3f, 8'hff);
    foreach (mds[i]) begin
      host.rd(8'h02 + mds[i][3:2] + {mds[i][4], 2'b00}, d);
      chk("reset value", 16'h0000, {8'h00, d});
    end
    cmd(8'hc2, 8'hff);
    cmd(8'hc1, 8'h81);
    foreach (ops[i]) foreach (mds[j]) begin
      op = ops[i];
      mode = mds[j];
      host.wr(8'h02, op);
      host.wr(8'h03, mode);
      foreach (cds[k]) begin
        r = xs();
        osc_freq_ok <= r[0];
        fifo_busy <= r[1];
        cmd(cds[k], 8'hff);
      end
    end
    op = 8'h80;
    host.wr(8'h02, op);
    host.wr(8'h03, 8'h1f);
    host.wr(8'h09, 8'h23);
    cmd(8'hc1, 8'h01);
    host.rd(8'h03, d);
    chk("mode", 16'h0000, {8'h00, d});
    host.rd(8'h02, d);
    chk("op kept", 16'h0080, {8'h00, d});
    r = xs();
    r[4] = 1'b1;
    detected_bitrate <= r;
    cmd(8'hcb, 8'h00);
    host.rd(8'h04, d);
    chk("bitrate", 16'h0000, {8'h00, d});
    host.wr(8'h03, 8'h02);
    cmd(8'hcb, 8'h00);
    host.rd(8'h04, d);
    chk("bitrate", {8'h00, r}, {8'h00, d});
    host.rd(8'h09, d);
    chk("modulation", {15'h0, |r[1:0]}, {15'h0, d[5]});
    host.rd(8'h03, d);
    chk("detect mode", 16'h0000, {15'h0, d[1]});
    osc_ampl_ok <= 1'b0;
    host.wr(8'h1c, 8'hc8);
    host.rd(8'h1b, d);
    chk("status", {13'h0, fifo_busy, 2'b00}, {13'h0, d[2:0]});
    osc_ampl_ok <= 1'b1;
    osc_freq_ok <= 1'b1;
    fon(8'hc8, 8'h00, 1'b0, 4096 * D + G);
    fon(8'hc9, 8'h01, 1'b0, (768 + 512 + 1024) * D);
    fon(8'hca, 8'h03, 1'b0, (768 + 1024) * D);
    fon(8'hc8, 8'h00, 1'b1, 0);
    // clear during response avoidance, with and without auto avoid
    ext_field <= 1'b0;
    host.wr(8'h03, 8'h00);
    host.wr(8'h1c, 8'hc9);
    host.wr(8'h1c, 8'hc2);
    host.rd(8'h1b, d);
    chk("clear stops", 16'h0000, {14'h0, d[1:0]});
    host.wr(8'h03, 8'h01);
    host.wr(8'h1c, 8'hc9);
    host.wr(8'h1c, 8'hc2);
    host.rd(8'h1b, d);
    chk("clear keeps", 16'h0001, {14'h0, d[1:0]});
    final_report();
  end
  // watchdog against a hung sequence
  initial begin
    repeat (60000) @(posedge core_clk);
    err_total++;
    final_report();
  end
endmodule // tb
bind nfc_direct_command_executor nfc_cmd_checker i_chk (
  .core_clk(core_clk), .rst_n(rst_n), .addr(addr), .wdata(wdata),
  .wr_stb(wr_stb), .osc_freq_ok(osc_freq_ok), .fifo_flush(fifo_flush),
  .tx_abort(tx_abort), .timers_stop(timers_stop), .nrt_stop(nrt_stop),
  .tx_start(tx_start), .tx_kind(tx_kind), .adj_reg_start(adj_reg_start),
  .mask_timer_start(mask_timer_start), .cal_discard(cal_discard));
`default_nettype wire
